// file: verilog/acis_top.sv
// Purpose: apb register and route selection for converter channels 1, 2, 3
// Assumes: twelve_bit_conv_select, opamp enables and alt sample come from pins
// Notes:   routes are registered behind the pin synchronisers, so they follow pins three cycles late
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module acis_top
  import acis_pkg::*;
#(
  parameter logic [11:0] SEL_ADDR     = ACIS_SEL_OFFSET,
  parameter bit          POS_A_LIKE_B = 1'b1
)
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output      logic        pready,
  output      logic [31:0] prdata,
  output      logic        pslverr,
  input  wire logic        twelve_bit_conv_select,
  input  wire logic [2:0]  opamp_route_enable,
  input  wire logic        alt_sample_b,
  output      acis_route_t pos_route,
  output      acis_route_t neg_route,
  output      logic        using_setting_b
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  // low address bits are not decoded, so only word placement works
  if (SEL_ADDR[1:0] != 2'b00) begin : g_bad_addr
    $error("acis_top: SEL_ADDR must be word aligned");
  end
  // setting a positive input is only built with the setting b encoding
  if (!POS_A_LIKE_B) begin : g_bad_pos_a
    $error("acis_top: POS_A_LIKE_B other than 1 is not built");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [4:0] sync1_r, sync2_r, sync1_nxt, sync2_nxt;

  always_comb begin
    sync1_nxt = {twelve_bit_conv_select, opamp_route_enable, alt_sample_b};
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else if (clk_en) begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  logic       twelve_s;
  logic [2:0] opamp_s;
  logic       alt_s;
  assign twelve_s = sync2_r[4];
  assign opamp_s  = sync2_r[3:1];
  assign alt_s    = sync2_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  logic        sel_hit;
  logic        acc;
  logic [15:0] sel_r, sel_nxt;
  logic [31:0] prdata_nxt;
  logic        pslverr_nxt;
  logic        pready_nxt;
  logic        wr_go;

  assign acc     = psel && !penable;
  assign sel_hit = (paddr[11:2] == SEL_ADDR[11:2]);
  // write waits for the access edge, so an abandoned setup changes nothing
  assign wr_go   = psel && penable && pready && pwrite && sel_hit && !twelve_s;

  always_comb begin
    sel_nxt     = sel_r;
    prdata_nxt  = prdata;
    pslverr_nxt = 1'b0;
    pready_nxt  = 1'b0;
    if (acc) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !sel_hit;
      prdata_nxt  = 32'h0000_0000;
      if (sel_hit && !pwrite && !twelve_s) begin
        prdata_nxt = {16'h0000, sel_r & ACIS_SEL_MASK};
      end
    end
    // writes in 12-bit mode are dropped, fields stay unimplemented
    if (wr_go) begin
      if (pstrb[0]) begin
        sel_nxt[7:0] = pwdata[7:0] & ACIS_SEL_MASK[7:0];
      end
      if (pstrb[1]) begin
        sel_nxt[15:8] = pwdata[15:8] & ACIS_SEL_MASK[15:8];
      end
    end
  end

  // answer rises in the access cycle, registered from setup
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sel_r   <= ACIS_SEL_RESET;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else if (clk_en) begin
      sel_r   <= sel_nxt;
      prdata  <= prdata_nxt;
      pslverr <= pslverr_nxt;
      pready  <= pready_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // route selection
  acis_sel_t   fld;
  acis_route_t pos_a, neg_a, pos_b, neg_b;
  acis_route_t pos_nxt, neg_nxt;
  logic        use_b_nxt;

  always_comb begin
    fld = '{neg_b: sel_r[ACIS_NB_LSB +: 2], pos_b: sel_r[ACIS_SB_BIT],
            neg_a: sel_r[ACIS_NA_LSB +: 2], pos_a: sel_r[ACIS_SA_BIT]};
    if (twelve_s) begin
      fld = '0;
    end
  end

  acis_route_map u_map_a (
    .neg_sel            (fld.neg_a),
    .pos_sel            (fld.pos_a),
    .opamp_route_enable (opamp_s),
    .pos_route          (pos_a),
    .neg_route          (neg_a)
  );

  acis_route_map u_map_b (
    .neg_sel            (fld.neg_b),
    .pos_sel            (fld.pos_b),
    .opamp_route_enable (opamp_s),
    .pos_route          (pos_b),
    .neg_route          (neg_b)
  );

  always_comb begin
    use_b_nxt = alt_s;
    pos_nxt   = use_b_nxt ? pos_b : pos_a;
    neg_nxt   = use_b_nxt ? neg_b : neg_a;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pos_route       <= '{ch1: ACIS_AN0, ch2: ACIS_AN1, ch3: ACIS_AN2};
      neg_route       <= '{ch1: ACIS_VREFL, ch2: ACIS_VREFL, ch3: ACIS_VREFL};
      using_setting_b <= 1'b0;
    end else if (clk_en) begin
      pos_route       <= pos_nxt;
      neg_route       <= neg_nxt;
      using_setting_b <= use_b_nxt;
    end
  end

endmodule : acis_top

// file: include/acis_pkg.sv
// Purpose: constants and types for the channel 1/2/3 input select block
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes:   pin codes name analog inputs, op-amp outputs and low reference
// Notes on behaviour
// - setting b negative code 11 gives inputs 9/10/11, 10 gives 6or-opamp3/7/8, 0x low ref
// - setting b positive bit 1 gives opamp1/3, opamp2/0, opamp3/6; 0 gives opamp2/0,1,2
// - setting a negative field maps exactly like setting b
// - in 12-bit mode select fields read zero and writes do not change selection
// - op-amp output routed when its enable is 1, otherwise the analog pin
// - bits 15-11 and 7-3 read zero, writes ignored
package acis_pkg;

  localparam logic [11:0] ACIS_SEL_OFFSET = 12'h000;
  localparam logic [15:0] ACIS_SEL_RESET  = 16'h0000;
  localparam logic [15:0] ACIS_SEL_MASK   = 16'h0707;
  localparam int          ACIS_NB_LSB     = 9;
  localparam int          ACIS_SB_BIT     = 8;
  localparam int          ACIS_NA_LSB     = 1;
  localparam int          ACIS_SA_BIT     = 0;

  // route codes: 0..11 analog input n, 16..18 op-amp output 1..3, 31 low reference
  localparam logic [4:0] ACIS_AN0   = 5'h00;
  localparam logic [4:0] ACIS_AN1   = 5'h01;
  localparam logic [4:0] ACIS_AN2   = 5'h02;
  localparam logic [4:0] ACIS_AN3   = 5'h03;
  localparam logic [4:0] ACIS_AN6   = 5'h06;
  localparam logic [4:0] ACIS_AN7   = 5'h07;
  localparam logic [4:0] ACIS_AN8   = 5'h08;
  localparam logic [4:0] ACIS_AN9   = 5'h09;
  localparam logic [4:0] ACIS_AN10  = 5'h0A;
  localparam logic [4:0] ACIS_AN11  = 5'h0B;
  localparam logic [4:0] ACIS_OA1   = 5'h10;
  localparam logic [4:0] ACIS_OA2   = 5'h11;
  localparam logic [4:0] ACIS_OA3   = 5'h12;
  localparam logic [4:0] ACIS_VREFL = 5'h1F;

  typedef struct packed {
    logic [1:0] neg_b;
    logic       pos_b;
    logic [1:0] neg_a;
    logic       pos_a;
  } acis_sel_t;

  typedef struct packed {
    logic [4:0] ch1;
    logic [4:0] ch2;
    logic [4:0] ch3;
  } acis_route_t;

endpackage : acis_pkg

// file: verilog/acis_route_map.sv
// Purpose: combinational map of one setting's fields onto three channel routes
// Assumes: opamp enables are already synchronised to core_clk
// Notes:   instanced once per setting
`timescale 1ns/1ps
module acis_route_map
  import acis_pkg::*;
(
  input  wire logic [1:0]  neg_sel,
  input  wire logic        pos_sel,
  input  wire logic [2:0]  opamp_route_enable,
  output      acis_route_t pos_route,
  output      acis_route_t neg_route
);

  function automatic logic [4:0] pick(input logic en, input logic [4:0] oa,
                                      input logic [4:0] an);
    pick = en ? oa : an;
  endfunction : pick

  always_comb begin
    case (neg_sel)
      2'b11: begin
        neg_route = '{ch1: ACIS_AN9, ch2: ACIS_AN10, ch3: ACIS_AN11};
      end
      2'b10: begin
        neg_route = '{ch1: pick(opamp_route_enable[2], ACIS_OA3, ACIS_AN6),
                      ch2: ACIS_AN7, ch3: ACIS_AN8};
      end
      default: begin
        neg_route = '{ch1: ACIS_VREFL, ch2: ACIS_VREFL, ch3: ACIS_VREFL};
      end
    endcase
    if (pos_sel) begin
      pos_route = '{ch1: pick(opamp_route_enable[0], ACIS_OA1, ACIS_AN3),
                    ch2: pick(opamp_route_enable[1], ACIS_OA2, ACIS_AN0),
                    ch3: pick(opamp_route_enable[2], ACIS_OA3, ACIS_AN6)};
    end else begin
      pos_route = '{ch1: pick(opamp_route_enable[1], ACIS_OA2, ACIS_AN0),
                    ch2: ACIS_AN1, ch3: ACIS_AN2};
    end
  end

endmodule : acis_route_map

// file: sim/acis_chk.sv
// Purpose: port checker for acis_top
// Assumes: clk_en is held high by the bench
// Notes:   pins reach the routes three edges late
`timescale 1ns/1ps
module acis_chk
  import acis_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        twelve_bit_conv_select,
  input wire logic [2:0]  opamp_route_enable,
  input wire logic        alt_sample_b,
  input wire acis_route_t pos_route,
  input wire acis_route_t neg_route,
  input wire logic        using_setting_b
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
////////////////////////////////////////
  answer_next_a: assert property (psel && !penable |=> pready)
    else $error("no answer");
  bad_addr_a: assert property (psel && !penable && paddr[11:2] != 10'h000 |=> pslverr)
    else $error("no slave error");
  unimpl_zero_a: assert property (pready && !pwrite |-> prdata[31:11] == 21'h0 &&
    prdata[7:3] == 5'h00) else $error("unimplemented bits set");
  twelve_read_a: assert property (pready && !pwrite && $past(twelve_bit_conv_select, 2) &&
    $past(twelve_bit_conv_select, 3) |-> prdata == 32'h0) else $error("field seen in 12-bit");
  neg_trio_a: assert property (neg_route.ch2 == ACIS_AN7 |-> neg_route.ch3 == ACIS_AN8 &&
    neg_route.ch1 == ($past(opamp_route_enable[2], 3) ? ACIS_OA3 : ACIS_AN6))
    else $error("negative route mixed");
  pos_trio_a: assert property (pos_route.ch2 == ACIS_AN1 |-> pos_route.ch3 == ACIS_AN2 &&
    pos_route.ch1 == ($past(opamp_route_enable[1], 3) ? ACIS_OA2 : ACIS_AN0))
    else $error("positive route mixed");
  setting_b_a: assert property (using_setting_b == $past(alt_sample_b, 3))
    else $error("setting choice late");
endmodule : acis_chk
bind acis_top acis_chk u_chk (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pready,
  .prdata, .pslverr, .twelve_bit_conv_select, .opamp_route_enable, .alt_sample_b, .pos_route,
  .neg_route, .using_setting_b);

// file: sim/adc_ch123_input_select_tb_top.sv
// Purpose: register and route bench for acis_top
// Assumes: clk_en held high, all strobes high except one upper-lane-only write
// Notes:   waits of five edges cover the pin synchronisers
`timescale 1ns/1ps
module adc_ch123_input_select_tb_top;
  import acis_pkg::*;
  logic        core_clk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        twelve_bit_conv_select = 1'h0, alt_sample_b = 1'h0, pready, pslverr, err;
  logic        using_setting_b;
  logic [2:0]  opamp_route_enable = 3'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  acis_route_t pos_route, neg_route;
  int          num_errors = 0, checks_done = 0;
  acis_top uut (.core_clk, .srst, .clk_en(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .twelve_bit_conv_select, .opamp_route_enable,
    .alt_sample_b, .pos_route, .neg_route, .using_setting_b);
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
////////////////////////////////////////
  function automatic acis_route_t eneg(input logic [1:0] c, input logic [2:0] oe);
    if (c == 2'h3) return {ACIS_AN9, ACIS_AN10, ACIS_AN11};
    if (c == 2'h2) return {oe[2] ? ACIS_OA3 : ACIS_AN6, ACIS_AN7, ACIS_AN8};
    return {3{ACIS_VREFL}};
  endfunction : eneg
  function automatic acis_route_t epos(input logic s, input logic [2:0] oe);
    if (s) return {oe[0] ? ACIS_OA1 : ACIS_AN3, oe[1] ? ACIS_OA2 : ACIS_AN0,
      oe[2] ? ACIS_OA3 : ACIS_AN6};
    return {oe[1] ? ACIS_OA2 : ACIS_AN0, ACIS_AN1, ACIS_AN2};
  endfunction : epos
  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    // a missing answer counts as a mismatch and ends the run
    if (pready !== 1'h1) begin
      num_errors++;
      results();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge core_clk);
    end
  endtask : apb
////////////////////////////////////////
  initial begin
    int c, s;
    logic [2:0] oe;
    repeat (3) @(posedge core_clk);
    srst <= 1'h0;
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk(32'(neg_route), 32'(eneg(2'h0, 3'h0)));
    apb(1'h1, 12'h000, 32'hFFFFFFFF);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0707);
    chk(32'(err), 32'h0);
    // only the upper lane is written, so the lower fields must survive
    pstrb <= 4'h2;
    apb(1'h1, 12'h000, 32'h0);
    pstrb <= 4'hF;
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0007);
    apb(1'h0, 12'h004, 32'h0);
    chk(32'(err), 32'h1);
    for (c = 0; c < 4; c++) begin
      for (s = 0; s < 2; s++) begin
        oe = 3'(c * 3 + s);
        opamp_route_enable <= oe;
        apb(1'h1, 12'h000, 32'((c << 9) | (s << 8) | ((3 - c) << 1) | (1 - s)));
        repeat (5) @(posedge core_clk);
        chk(32'(neg_route), 32'(eneg(2'(3 - c), oe)));
        chk(32'(pos_route), 32'(epos(1'(1 - s), oe)));
        chk(32'(using_setting_b), 32'h0);
        alt_sample_b <= 1'h1;
        repeat (5) @(posedge core_clk);
        chk(32'(neg_route), 32'(eneg(2'(c), oe)));
        chk(32'(pos_route), 32'(epos(1'(s), oe)));
        chk(32'(using_setting_b), 32'h1);
        alt_sample_b <= 1'h0;
      end
    end
    // setting b field holds code 3, so a forced zero is visible
    alt_sample_b <= 1'h1;
    twelve_bit_conv_select <= 1'h1;
    repeat (5) @(posedge core_clk);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk(32'(neg_route), 32'(eneg(2'h0, oe)));
    chk(32'(pos_route), 32'(epos(1'h0, oe)));
    apb(1'h1, 12'h000, 32'h0101);
    twelve_bit_conv_select <= 1'h0;
    repeat (5) @(posedge core_clk);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0700);
    results();
  end
endmodule : adc_ch123_input_select_tb_top
